// file: verilog/gst_regs.vh
// Purpose: register map and field layout of the gated 16-bit timer
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: all offsets are byte addresses
`ifndef GST_REGS_VH
`define GST_REGS_VH
`define GST_CTRL_OFS 8'h00
`define GST_GATE_OFS 8'h04
`define GST_COUNT_OFS 8'h08
`define GST_STAT_OFS 8'h0C
`define GST_MASK_OFS 8'h10
`define GST_IRQEN_OFS 8'h14
`define GST_CTRL_ON 0
`define GST_CTRL_SYNC_N 2
`define GST_CTRL_PS_LO 4
`define GST_CTRL_CS 6
`define GST_GATE_SS_LO 0
`define GST_GATE_VAL 2
`define GST_GATE_POL 6
`define GST_GATE_EN 7
`define GST_ST_OVF 0
`define GST_ST_GATE 1
`define GST_IRQEN_PERI 0
`define GST_IRQEN_GLOB 1
`define GST_RESP_OKAY 2'h0
`define GST_RESP_SLVERR 2'h2
`endif

// file: verilog/gst_timer.v
// Purpose: gated 16-bit timer/counter with prescaler and AXI4-Lite registers
// Assumes: one clock; external clock and gate pins are asynchronous
// Notes: instantiate once per timer
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`include "gst_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module gst_timer #(
  // every instance is this same module; only its place and NUM_GATES may differ
  parameter NUM_GATES = 4
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // axi4-lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // pins and partner logic
  input wire ext_clk_pin,
  input wire [NUM_GATES-1:0] gate_src,
  input wire auto_conv_trig,
  input wire sleep_mode,
  // outputs
  output reg [15:0] time_base,
  output reg cmp_sync_clk,
  output reg wake_req,
  output reg irq
);
  // address decode used by both read and write paths
  function [2:0] dec;
    input [7:0] a;
    begin
      case (a)
        `GST_CTRL_OFS: dec = 3'h0;
        `GST_GATE_OFS: dec = 3'h1;
        `GST_COUNT_OFS: dec = 3'h2;
        `GST_STAT_OFS: dec = 3'h3;
        `GST_MASK_OFS: dec = 3'h4;
        `GST_IRQEN_OFS: dec = 3'h5;
        default: dec = 3'h7;
      endcase
    end
  endfunction

  reg [7:0] ctrl_reg;
  reg [7:0] gate_reg;
  reg [15:0] cnt_reg;
  reg [1:0] stat_reg;
  reg [1:0] mask_reg;
  reg [1:0] irqen_reg;
  reg [2:0] psc_reg;
  reg [1:0] ext_sync_reg;
  reg ext_prev_reg;
  reg [NUM_GATES-1:0] gate_s1_reg;
  reg [NUM_GATES-1:0] gate_s2_reg;
  reg gval_reg;
  reg [7:0] awaddr_reg;
  reg aw_have_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg w_have_reg;

  // synchronisers: first stage read only by second
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_sync_reg <= 2'h0;
      gate_s1_reg <= {NUM_GATES{1'b0}};
      gate_s2_reg <= {NUM_GATES{1'b0}};
    end
    else
    begin
      ext_sync_reg <= {ext_sync_reg[0], ext_clk_pin};
      gate_s1_reg <= gate_src;
      gate_s2_reg <= gate_s1_reg;
    end
  end

  wire ext_rise = ext_sync_reg[1] & ~ext_prev_reg;
  // internal clock ticks every cycle; external on its synced rising edge
  wire src_tick = ctrl_reg[`GST_CTRL_CS] ? ext_rise : 1'b1;
  wire gate_sel = gate_s2_reg[gate_reg[`GST_GATE_SS_LO +: 2]];
  wire gate_lvl = gate_sel ^ ~gate_reg[`GST_GATE_POL];
  wire gate_ok = ~gate_reg[`GST_GATE_EN] | gate_lvl;
  wire [1:0] psel = ctrl_reg[`GST_CTRL_PS_LO +: 2];
  // prescaler output: divides ticks by 1, 2, 4 or 8
  wire [2:0] psc_mask = (psel == 2'h0) ? 3'h0 :
                        (psel == 2'h1) ? 3'h1 :
                        (psel == 2'h2) ? 3'h3 : 3'h7;
  wire run = ctrl_reg[`GST_CTRL_ON] & gate_ok;
  wire inc = run & src_tick & ((psc_reg & psc_mask) == psc_mask);
  wire wrap = inc & (cnt_reg == 16'hFFFF);
  // gate falling edge seen regardless of gate enable
  wire gate_fall = gval_reg & ~gate_lvl;

  // write-one clear acts only at commit, never while the request waits
  wire wr_commit = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  wire stat_wr = wr_commit & (dec(awaddr_reg) == 3'h3) & wstrb_reg[0];
  wire [1:0] w1c = stat_wr ? wdata_reg[1:0] : 2'h0;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GST_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      ctrl_reg <= 8'h00;
      gate_reg <= 8'h00;
      mask_reg <= 2'h0;
      irqen_reg <= 2'h0;
    end
    else
    begin
      s_axi_awready <= ~aw_have_reg & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_have_reg & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_reg & w_have_reg & ~s_axi_bvalid)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (dec(awaddr_reg) == 3'h7) ? `GST_RESP_SLVERR :
                       `GST_RESP_OKAY;
        if (wstrb_reg[0])
        begin
          case (dec(awaddr_reg))
            3'h0: ctrl_reg <= wdata_reg[7:0];
            // gate value bit is read-only status
            3'h1: gate_reg <= wdata_reg[7:0] & 8'hFB;
            3'h4: mask_reg <= wdata_reg[1:0];
            3'h5: irqen_reg <= wdata_reg[1:0];
            default: ;
          endcase
        end
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // register writes commit only when both are held, so count writes too
  wire cnt_commit = aw_have_reg & w_have_reg & ~s_axi_bvalid &
                    (dec(awaddr_reg) == 3'h2);

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg <= 16'h0000;
      psc_reg <= 3'h0;
      ext_prev_reg <= 1'b0;
      gval_reg <= 1'b0;
      stat_reg <= 2'h0;
      time_base <= 16'h0000;
      cmp_sync_clk <= 1'b0;
      wake_req <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      ext_prev_reg <= ext_sync_reg[1];
      gval_reg <= gate_lvl;
      if (run & src_tick)
        psc_reg <= psc_reg + 3'h1;
      if (cnt_commit)
      begin
        // software write beats a coincident trigger clear
        if (wstrb_reg[0])
          cnt_reg[7:0] <= wdata_reg[7:0];
        if (wstrb_reg[1])
          cnt_reg[15:8] <= wdata_reg[15:8];
      end
      else if (auto_conv_trig)
        cnt_reg <= 16'h0000;
      else if (inc)
        cnt_reg <= cnt_reg + 16'h0001;
      // set wins over the write-one clear
      stat_reg[`GST_ST_OVF] <= (stat_reg[`GST_ST_OVF] &
        ~w1c[`GST_ST_OVF]) | (wrap & ~auto_conv_trig);
      stat_reg[`GST_ST_GATE] <= (stat_reg[`GST_ST_GATE] &
        ~w1c[`GST_ST_GATE]) | gate_fall;
      time_base <= cnt_reg;
      cmp_sync_clk <= ctrl_reg[`GST_CTRL_CS] ? ext_sync_reg[1] :
                      psc_reg[0];
      // wake only from an asynchronous external-clock overflow
      wake_req <= sleep_mode & wrap & ctrl_reg[`GST_CTRL_CS] &
                  ctrl_reg[`GST_CTRL_SYNC_N];
      irq <= irqen_reg[`GST_IRQEN_PERI] & irqen_reg[`GST_IRQEN_GLOB] &
             ((stat_reg[`GST_ST_OVF] & mask_reg[`GST_ST_OVF] &
               ctrl_reg[`GST_CTRL_ON]) |
              (stat_reg[`GST_ST_GATE] & mask_reg[`GST_ST_GATE]));
    end
  end

  // read channel: one outstanding read, answer one cycle after accept
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `GST_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~s_axi_arvalid;
      if (s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready)
        s_axi_arready <= 1'b1;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `GST_RESP_OKAY;
        case (dec(s_axi_araddr))
          3'h0: s_axi_rdata <= {24'h000000, ctrl_reg};
          3'h1: s_axi_rdata <= {24'h000000, gate_reg[7:3], gval_reg,
                                gate_reg[1:0]};
          3'h2: s_axi_rdata <= {16'h0000, cnt_reg};
          3'h3: s_axi_rdata <= {30'h00000000, stat_reg};
          3'h4: s_axi_rdata <= {30'h00000000, mask_reg};
          3'h5: s_axi_rdata <= {30'h00000000, irqen_reg};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `GST_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb/gst_far_end.sv
// Purpose: far-side model: gate pins, external clock, compare unit
// Assumes: bench steers the gate level and the trigger requests
// Notes: unused gate inputs toggle so a wrong source select shows
`timescale 1ns/1ps
`default_nettype none
module gst_far_end (
  // from bench
  input wire logic clk,
  input wire logic gate_lvl,
  input wire logic trig_req,
  // toward the timer
  output logic ext_clk_pin,
  output logic [3:0] gate_src,
  output logic auto_conv_trig
);
  logic [1:0] div_reg = 2'h0;
  logic trig_d = 1'b0;
  initial gate_src = 4'h0;
  // crystal runs free at a quarter of the system rate
  always @(posedge clk)
  begin
    div_reg <= div_reg + 2'h1;
    gate_src <= {~gate_src[3:1], gate_lvl};
    trig_d <= trig_req;
  end
  assign ext_clk_pin = div_reg[1];
  // one-cycle pulse per request, as a compare match gives
  assign auto_conv_trig = trig_req & ~trig_d;
endmodule
`default_nettype wire

// file: tb/gst_timer_properties.sv
// Purpose: port checks for the gated timer
// Assumes: one clock, rstn asynchronous active low
// Notes: bound to every gst_timer instance
`timescale 1ns/1ps
`default_nettype none
module gst_props (
  // clock and reset
  input wire clk,
  input wire rstn,
  // bus
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // timer side
  input wire auto_conv_trig,
  input wire sleep_mode,
  input wire [15:0] time_base,
  input wire wake_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_wr_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wr_answer;
    s_wr_taken |-> ##[1:4] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response missing");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("bvalid dropped early");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read data late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("refused read carries data");
  property p_wake;
    wake_req |-> $past(sleep_mode) ##1 !wake_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake pulse wrong");
  // a count write up to two edges back may win, so keep it out
  property p_trig_clear;
    auto_conv_trig && !s_axi_bvalid && !s_axi_wvalid &&
      !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2)
      |-> ##2 time_base == 16'h0000;
  endproperty
  a_trig_clear: assert property (p_trig_clear)
    else $error("trigger left count");
  property p_count_step;
    $changed(time_base) && !$past(s_axi_bvalid) |->
      time_base == $past(time_base) + 16'h0001 || time_base == 16'h0000;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count jumped");
endmodule
bind gst_timer gst_props i_gst_props (.*);
`default_nettype wire

// file: tb/tb_gst_timer.sv
// Purpose: register-level regression of the gated timer
// Assumes: 40 MHz clock, far-side model drives the pins
// Notes: count values read back are checked by masks, bus timing varies
`include "gst_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_gst_timer;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ext_clk_pin, auto_conv_trig, cmp_sync_clk;
  logic wake_req, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] time_base;
  logic [3:0] gate_src;
  logic sleep_mode = 1'b0;
  logic gate_lvl = 1'b0;
  logic trig_req = 1'b0;
  logic saw_wake = 1'b0;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  gst_timer #(.NUM_GATES(4)) i_gst_timer (.*);
  gst_far_end i_gst_far_end (.*);
  always #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // whole run needs about 260 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (wake_req) saw_wake <= 1'b1;
    if (cycles == 5000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(`GST_CTRL_OFS, 32'hFFFFFFFF, 32'h0, 2'h0);
    rdc(8'h40, 32'hFFFFFFFF, 32'h0, 2'h2);
    wr(`GST_COUNT_OFS, 32'hFFFD);
    wr(`GST_CTRL_OFS, 32'h1);
    repeat (10) @(posedge clk);
    rdc(`GST_STAT_OFS, 32'h1, 32'h1, 2'h0);
    wr(`GST_MASK_OFS, 32'h1);
    wr(`GST_IRQEN_OFS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`GST_IRQEN_OFS, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(`GST_STAT_OFS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`GST_COUNT_OFS, 32'hFFF0);
    trig_req <= 1'b1;
    repeat (2) @(posedge clk);
    trig_req <= 1'b0;
    repeat (30) @(posedge clk);
    rdc(`GST_STAT_OFS, 32'h1, 32'h0, 2'h0);
    rdc(`GST_COUNT_OFS, 32'hFF00, 32'h0, 2'h0);
    // polarity change itself makes a falling edge, so clear after it
    wr(`GST_GATE_OFS, 32'h40);
    wr(`GST_STAT_OFS, 32'h2);
    gate_lvl <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(`GST_GATE_OFS, 32'h4, 32'h4, 2'h0);
    gate_lvl <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(`GST_STAT_OFS, 32'h2, 32'h2, 2'h0);
    wr(`GST_MASK_OFS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(`GST_CTRL_OFS, 32'h0);
    wr(`GST_COUNT_OFS, 32'h0);
    gate_lvl <= 1'b1;
    wr(`GST_GATE_OFS, 32'h80);
    wr(`GST_CTRL_OFS, 32'h1);
    repeat (20) @(posedge clk);
    rdc(`GST_COUNT_OFS, 32'hFFFF, 32'h0, 2'h0);
    chk({16'h0, time_base}, 32'h0);
    wr(`GST_GATE_OFS, 32'h0);
    // stop the internal count so only the external clock can wrap
    wr(`GST_CTRL_OFS, 32'h44);
    wr(`GST_COUNT_OFS, 32'hFFFE);
    sleep_mode <= 1'b1;
    wr(`GST_CTRL_OFS, 32'h45);
    repeat (40) @(posedge clk);
    rdc(`GST_STAT_OFS, 32'h1, 32'h1, 2'h0);
    chk({31'h0, saw_wake}, 32'h1);
    results();
  end
endmodule
`default_nettype wire
